// ### shared/atd_pkg.sv
// atd_pkg: constants for the parallel task-file decoder.
// assumes the host port pins are sampled into the clk_sys domain.
package atd_pkg;
  // ==========================================================
  // address codes on the three address lines
  localparam logic [2:0] ATD_A_DATA   = 3'h0;
  localparam logic [2:0] ATD_A_ERRFEA = 3'h1;
  localparam logic [2:0] ATD_A_SCNT   = 3'h2;
  localparam logic [2:0] ATD_A_SNUM   = 3'h3;
  localparam logic [2:0] ATD_A_CYLL   = 3'h4;
  localparam logic [2:0] ATD_A_CYLH   = 3'h5;
  localparam logic [2:0] ATD_A_DEVHD  = 3'h6;
  localparam logic [2:0] ATD_A_STCMD  = 3'h7;
  localparam logic [2:0] ATD_A_ALTCTL = 3'h6;
  localparam logic [2:0] ATD_A_DRVADR = 3'h7;
  // ==========================================================
  // field positions and values
  localparam int         ATD_CTL_SOFTWARE_RESET_BIT  = 2;
  localparam int         ATD_CTL_NIEN  = 1;
  localparam int         ATD_DH_LBA    = 6;
  localparam int         ATD_DH_DRV    = 4;
  localparam int         ATD_ST_BSY    = 7;
  localparam logic [7:0] ATD_CMD_CHKPWR = 8'h00_E5;
  localparam logic [7:0] ATD_PWR_IDLE   = 8'h00_FF;
  localparam logic [7:0] ATD_PWR_FORBID = 8'h00_80;
  localparam logic [7:0] ATD_ST_RESET   = 8'h00_50;
  localparam logic [7:0] ATD_ST_BUSY    = 8'h00_80;
  localparam logic [7:0] ATD_DIAG_OK    = 8'h00_01;
  localparam logic [7:0] ATD_ZERO8      = 8'h00_00;
  localparam logic [7:0] ATD_ONE8       = 8'h00_01;
  localparam logic [15:0] ATD_ZERO16    = 16'h0000;
  localparam logic [1:0] ATD_STB_PEND   = 2'h1;
endpackage : atd_pkg

// ### rtl/atd_sync.sv
// atd_sync: two-flop synchroniser for a vector of pin levels.
// assumes one clock; inputs arrive asynchronously.
`timescale 1ns/10ps
module atd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  // only the second stage is read downstream
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : atd_sync

// ### rtl/atd_task_file.sv
// atd_task_file: register select and task file of a parallel AT host port.
// assumes pins are level inputs from the host; strobes and selects are active low.
`timescale 1ns/10ps
module atd_task_file
  import atd_pkg::*;
#(
  parameter bit DEV_ID = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        hard_reset_n,
  input  wire logic        cs0_n,
  input  wire logic        cs1_n,
  input  wire logic [2:0]  da,
  input  wire logic        dior_n,
  input  wire logic        diow_n,
  input  wire logic [15:0] dd_in,
  output logic      [15:0] dd_out,
  output logic             dd_oe,
  output logic             intrq,
  output logic             cmd_start,
  output logic      [7:0]  cmd_code,
  output logic             soft_reset,
  output logic      [27:0] lba_addr,
  output logic             lba_mode,
  input  wire logic        cmd_done,
  input  wire logic        pwr_idle,
  input  wire logic [7:0]  core_status,
  input  wire logic [7:0]  core_error
);
  // ==========================================================
  // pin synchronisers
  logic        cs0_s_n, cs1_s_n, dior_s_n, diow_s_n, hrst_s_n;
  logic [2:0]  da_s;
  logic [15:0] dd_s;
  logic [23:0] pin_sync;
  atd_sync #(.W(24)) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({~hard_reset_n, ~cs0_n, ~cs1_n, ~dior_n, ~diow_n, da, dd_in}),
    .sync_out (pin_sync)
  );
  // low-active pins travel inverted so the flops' reset value means negated,
  // otherwise the first edges after reset would look like a strobe or hard reset
  assign {hrst_s_n, cs0_s_n, cs1_s_n, dior_s_n, diow_s_n} = ~pin_sync[23:19];
  assign {da_s, dd_s} = pin_sync[18:0];

  // ==========================================================
  // address decode
  wire cmd_blk = !cs0_s_n && cs1_s_n;
  wire ctl_blk = cs0_s_n && !cs1_s_n;
  wire ctl_hit = ctl_blk && (da_s == ATD_A_ALTCTL || da_s == ATD_A_DRVADR);
  wire valid   = cmd_blk || ctl_hit;
  wire rd_act  = !dior_s_n && valid;
  logic dior_d_q, diow_d_q;
  wire wr_edge = !diow_s_n && diow_d_q;
  wire rd_edge = !dior_s_n && dior_d_q;
  wire wr_cmd  = wr_edge && cmd_blk;
  wire wr_ctl  = wr_edge && ctl_blk && da_s == ATD_A_ALTCTL;
  wire rd_stat = rd_edge && cmd_blk && da_s == ATD_A_STCMD;

  // ==========================================================
  // task file registers
  logic [7:0] feat_q, scnt_q, snum_q, cyll_q, cylh_q, devhd_q, ctl_q, cmd_q;
  logic [7:0] err_q, stat_q;
  logic       pend_q, start_q, hr_d_q;
  wire        hard_rst = !hrst_s_n && hr_d_q;
  wire        software_reset_bit     = ctl_q[ATD_CTL_SOFTWARE_RESET_BIT];
  wire        go_cmd   = wr_cmd && da_s == ATD_A_STCMD && !software_reset_bit;
  wire        chkpwr   = go_cmd && dd_s[7:0] == ATD_CMD_CHKPWR;
  // never 80h: idle gives FFh, otherwise zero
  wire [7:0]  pwr_val  = pwr_idle ? ATD_PWR_IDLE : ATD_ZERO8;
  wire        selected = devhd_q[ATD_DH_DRV] == DEV_ID;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dior_d_q <= 1'b1;
      diow_d_q <= 1'b1;
      hr_d_q   <= 1'b1;
    end else begin
      dior_d_q <= dior_s_n;
      diow_d_q <= diow_s_n;
      hr_d_q   <= hrst_s_n;
    end
  end

  // power-on clears all but error (01h) and status (50h); hard reset keeps control and features
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {feat_q, scnt_q, snum_q, cyll_q, cylh_q, devhd_q, ctl_q, cmd_q} <= '0;
      err_q  <= ATD_DIAG_OK;
      stat_q <= ATD_ST_RESET;
    end else if (hard_rst) begin
      {scnt_q, snum_q, cyll_q, cylh_q, devhd_q} <= {ATD_ONE8, ATD_ONE8, ATD_ZERO8,
                                                   ATD_ZERO8, ATD_ZERO8};
      err_q  <= ATD_DIAG_OK;
      stat_q <= ATD_ST_RESET;
    end else begin
      if (wr_ctl) ctl_q <= dd_s[7:0];
      if (software_reset_bit) begin
        stat_q <= ATD_ST_BUSY;
        err_q  <= ATD_DIAG_OK;
      end else begin
        if (!stat_q[ATD_ST_BSY] && !software_reset_bit && wr_cmd) begin
          case (da_s)
            ATD_A_ERRFEA: feat_q  <= dd_s[7:0];
            ATD_A_SCNT:   scnt_q  <= dd_s[7:0];
            ATD_A_SNUM:   snum_q  <= dd_s[7:0];
            ATD_A_CYLL:   cyll_q  <= dd_s[7:0];
            ATD_A_CYLH:   cylh_q  <= dd_s[7:0];
            ATD_A_DEVHD:  devhd_q <= dd_s[7:0];
            ATD_A_STCMD:  cmd_q   <= dd_s[7:0];
            default:      cmd_q   <= cmd_q;
          endcase
        end
        if (chkpwr) scnt_q <= pwr_val;
        if (cmd_done) begin
          stat_q <= core_status;
          err_q  <= core_error;
        end else if (go_cmd && !chkpwr) stat_q <= ATD_ST_BUSY;
        // leaving software reset: ready again, else writes stay refused
        else if (soft_reset && !software_reset_bit) stat_q <= ATD_ST_RESET;
      end
    end
  end

  // ==========================================================
  // command start, pending interrupt
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
      pend_q  <= 1'b0;
    end else begin
      start_q <= go_cmd && !hard_rst;
      // completion wins over the status-read clear
      if (cmd_done || chkpwr) pend_q <= 1'b1;
      else if (rd_stat || software_reset_bit || hard_rst) pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // read mux
  wire [7:0] drv_adr = {1'b0, 1'b1, ~devhd_q[3:0], DEV_ID, ~DEV_ID};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = ATD_ZERO16;
    if (ctl_blk) begin
      rd_mux[7:0] = (da_s == ATD_A_ALTCTL) ? stat_q : drv_adr;
    end else begin
      case (da_s)
        ATD_A_DATA:   rd_mux = ATD_ZERO16;
        ATD_A_ERRFEA: rd_mux[7:0] = err_q;
        ATD_A_SCNT:   rd_mux[7:0] = scnt_q;
        ATD_A_SNUM:   rd_mux[7:0] = snum_q;
        ATD_A_CYLL:   rd_mux[7:0] = cyll_q;
        ATD_A_CYLH:   rd_mux[7:0] = cylh_q;
        ATD_A_DEVHD:  rd_mux[7:0] = devhd_q;
        ATD_A_STCMD:  rd_mux[7:0] = stat_q;
        default:      rd_mux = ATD_ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dd_out     <= '0;
      dd_oe      <= 1'b0;
      intrq      <= 1'b0;
      cmd_start  <= 1'b0;
      cmd_code   <= '0;
      soft_reset <= 1'b0;
      lba_addr   <= '0;
      lba_mode   <= 1'b0;
    end else begin
      dd_out     <= rd_act ? rd_mux : ATD_ZERO16;
      dd_oe      <= rd_act;
      intrq      <= pend_q && !ctl_q[ATD_CTL_NIEN] && selected;
      cmd_start  <= start_q;
      cmd_code   <= cmd_q;
      soft_reset <= software_reset_bit;
      lba_addr   <= {devhd_q[3:0], cylh_q, cyll_q, snum_q};
      lba_mode   <= devhd_q[ATD_DH_LBA];
    end
  end

  // ==========================================================
  // checks
  AST_FLOAT_NOSEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cs0_s_n && cs1_s_n) |=> !dd_oe) else $error("bus driven without select");
  AST_FLOAT_BOTH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!cs0_s_n && !cs1_s_n) |=> !dd_oe) else $error("bus driven on invalid address");
  AST_CTL_HOLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ctl_blk && !da_s[2]) |=> !dd_oe) else $error("control hole driven");
  AST_RD_DRIVE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd_act |=> dd_oe) else $error("read not driven");
  AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    dior_s_n |=> !dd_oe) else $error("bus held after strobe");
  AST_PWR_80: assert property (@(posedge clk_sys) disable iff (!reset_n)
    chkpwr && !hard_rst |=> scnt_q != ATD_PWR_FORBID) else $error("power result 80h");
  AST_PWR_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    chkpwr && pwr_idle && !hard_rst |=> scnt_q == ATD_PWR_IDLE) else $error("idle not FFh");
  AST_START: assert property (@(posedge clk_sys) disable iff (!reset_n)
    go_cmd && !hard_rst |=> ##1 cmd_start) else $error("command did not start");
  AST_ALT_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (pend_q && rd_edge && ctl_blk && !software_reset_bit && !hard_rst) |=> pend_q)
    else $error("alt status cleared interrupt");
  AST_IEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctl_q[ATD_CTL_NIEN] |=> !intrq) else $error("interrupt while disabled");
endmodule : atd_task_file

// ### bench/atd_host_model.sv
// atd_host_model: host adapter driving the parallel task-file pins.
// assumes clk_sys from the bench; one access at a time, called as a task.
`timescale 1ns/10ps
module atd_host_model (
  input  wire logic        clk_sys,
  output logic             cs0_n,
  output logic             cs1_n,
  output logic      [2:0]  da,
  output logic             dior_n,
  output logic             diow_n,
  output logic      [15:0] dd_in,
  input  wire logic [15:0] dd_out,
  input  wire logic        dd_oe
);
  initial begin
    {cs1_n, cs0_n, dior_n, diow_n} = 4'hF;
    da    = 3'h0;
    dd_in = 16'h0000;
  end
  // =======================================================
  // one strobed access, everything held until the last edge
  task automatic acc(input logic wr, input logic [1:0] cs, input logic [2:0] a,
                     input logic [15:0] wd, output logic [15:0] rd, output logic oe);
    @(posedge clk_sys);
    #1;
    {cs1_n, cs0_n} = cs;
    da     = a;
    dd_in  = wd;
    dior_n = wr;
    diow_n = !wr;
    repeat (6) @(posedge clk_sys);
    rd = dd_out;
    oe = dd_oe;
    #1;
    {cs1_n, cs0_n, dior_n, diow_n} = 4'hF;
    // released bus must not keep a stale value
    dd_in = ~wd;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : acc
endmodule : atd_host_model

// ### bench/ata_task_file_decoder_tb.sv
// ata_task_file_decoder_tb: self-checking bench for the task-file decoder.
// assumes atd_pkg and the host model are compiled first.
`timescale 1ns/10ps
module ata_task_file_decoder_tb;
  import atd_pkg::*;
  localparam logic [1:0] CMD = 2'h2;
  localparam logic [1:0] CTL = 2'h1;
  logic        clk_sys, reset_n, hard_reset_n, cmd_done, pwr_idle;
  logic        cs0_n, cs1_n, dior_n, diow_n, dd_oe, intrq, cmd_start, soft_reset, lba_mode;
  logic [2:0]  da;
  logic [7:0]  core_status, core_error, cmd_code;
  logic [15:0] dd_in, dd_out;
  logic [27:0] lba_addr;
  int          errors, check_count, starts;
  atd_task_file #(.DEV_ID(1'b0)) i_atd_task_file (.clk_sys(clk_sys), .reset_n(reset_n),
    .hard_reset_n(hard_reset_n), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
    .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe), .intrq(intrq),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .soft_reset(soft_reset),
    .lba_addr(lba_addr), .lba_mode(lba_mode), .cmd_done(cmd_done), .pwr_idle(pwr_idle),
    .core_status(core_status), .core_error(core_error));
  atd_host_model i_atd_host_model (.clk_sys(clk_sys), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .da(da), .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (cmd_start === 1'b1) starts++;
  // =======================================================
  // shared tasks
  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [1:0] cs, input logic [2:0] a, input logic [15:0] exp,
                    input logic exp_oe);
    logic [15:0] d;
    logic        oe;
    i_atd_host_model.acc(1'b0, cs, a, 16'h0000, d, oe);
    check("drive enable", oe, exp_oe);
    if (exp_oe) check("read data", d, exp);
    check("bus released", dd_oe, 1'b0);
  endtask : rd
  task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [15:0] v);
    logic [15:0] d;
    logic        oe;
    i_atd_host_model.acc(1'b1, cs, a, v, d, oe);
    check("write floats", oe, 1'b0);
  endtask : wr
  task automatic pulse_done(input logic [7:0] err);
    #1 core_error = err;
    cmd_done = 1'b1;
    @(posedge clk_sys);
    #1 cmd_done = 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse_done
  // =======================================================
  // scenarios
  task automatic t_floats;
    for (int a = 0; a < 8; a++) begin
      rd(2'h3, a[2:0], 16'h0000, 1'b0);
      rd(2'h0, a[2:0], 16'h0000, 1'b0);
      if (a < 6) rd(CTL, a[2:0], 16'h0000, 1'b0);
    end
    wr(CMD, ATD_A_SCNT, 16'h0012);
    wr(2'h3, ATD_A_SCNT, 16'h0077);
    wr(2'h0, ATD_A_SCNT, 16'h0077);
    rd(CMD, ATD_A_SCNT, 16'h0012, 1'b1);
  endtask : t_floats
  task automatic t_regs;
    rd(CMD, ATD_A_STCMD, 16'h0050, 1'b1);
    rd(CMD, ATD_A_ERRFEA, 16'h0001, 1'b1);
    wr(CMD, ATD_A_ERRFEA, 16'h0099);
    rd(CMD, ATD_A_ERRFEA, 16'h0001, 1'b1);
    wr(CMD, ATD_A_DATA, 16'hABCD);
    rd(CMD, ATD_A_DATA, 16'h0000, 1'b1);
    wr(CMD, ATD_A_SNUM, 16'h0011);
    wr(CMD, ATD_A_CYLL, 16'h0022);
    wr(CMD, ATD_A_CYLH, 16'h0033);
    wr(CMD, ATD_A_DEVHD, 16'h00E5);
    rd(CMD, ATD_A_SNUM, 16'h0011, 1'b1);
    rd(CMD, ATD_A_CYLL, 16'h0022, 1'b1);
    rd(CMD, ATD_A_CYLH, 16'h0033, 1'b1);
    rd(CMD, ATD_A_DEVHD, 16'h00E5, 1'b1);
    check("lba mode", lba_mode, 1'b1);
    check("lba address", lba_addr, 28'h533_2211);
  endtask : t_regs
  task automatic t_power_check;
    wr(CTL, ATD_A_ALTCTL, 16'h0000);
    pwr_idle = 1'b1;
    starts   = 0;
    wr(CMD, ATD_A_STCMD, 16'h00E5);
    check("start pulses", starts, 1);
    check("command code", cmd_code, 8'hE5);
    check("interrupt", intrq, 1'b1);
    rd(CMD, ATD_A_SCNT, 16'h00FF, 1'b1);
    rd(CTL, ATD_A_ALTCTL, 16'h0050, 1'b1);
    check("alt keeps irq", intrq, 1'b1);
    rd(CMD, ATD_A_STCMD, 16'h0050, 1'b1);
    check("status clears irq", intrq, 1'b0);
    pwr_idle = 1'b0;
    wr(CMD, ATD_A_STCMD, 16'h00E5);
    rd(CMD, ATD_A_SCNT, 16'h0000, 1'b1);
    pulse_done(8'h04);
    check("done irq", intrq, 1'b1);
    rd(CMD, ATD_A_ERRFEA, 16'h0004, 1'b1);
    wr(CMD, ATD_A_DEVHD, 16'h00F0);
    pulse_done(8'h00);
    check("other device irq", intrq, 1'b0);
  endtask : t_power_check
  task automatic t_hard_reset;
    wr(CTL, ATD_A_ALTCTL, 16'h0002);
    wr(CMD, ATD_A_DEVHD, 16'h0000);
    wr(CMD, ATD_A_SCNT, 16'h0033);
    wr(CMD, ATD_A_CYLL, 16'h0044);
    hard_reset_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 hard_reset_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(CMD, ATD_A_SCNT, 16'h0001, 1'b1);
    rd(CMD, ATD_A_SNUM, 16'h0001, 1'b1);
    rd(CMD, ATD_A_CYLL, 16'h0000, 1'b1);
    pulse_done(8'h00);
    check("disabled irq", intrq, 1'b0);
  endtask : t_hard_reset
  task automatic t_soft_reset;
    wr(CTL, ATD_A_ALTCTL, 16'h0004);
    check("soft reset on", soft_reset, 1'b1);
    repeat (1000) @(posedge clk_sys); // 5 us hold
    wr(CTL, ATD_A_ALTCTL, 16'h0000);
    check("soft reset off", soft_reset, 1'b0);
    rd(CMD, ATD_A_STCMD, 16'h0050, 1'b1);
  endtask : t_soft_reset
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // =======================================================
  // sequence and watchdog
  initial begin
    {reset_n, hard_reset_n, cmd_done, pwr_idle} = 4'h4;
    core_status = 8'h50;
    core_error  = 8'h00;
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    t_floats();
    t_regs();
    t_power_check();
    t_hard_reset();
    t_soft_reset();
    complete_run();
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule : ata_task_file_decoder_tb
